// ---- src/crt_pkg.sv ----
// constants, register map and types for the cascadable reload timer bank
package crt_pkg;

  localparam int CRT_DATA_W = 8;
  localparam int CRT_NUM_TIMERS = 10;
  localparam int CRT_NUM_GEN = 7;
  localparam int CRT_NUM_BAUD = 6;

  typedef logic [CRT_DATA_W-1:0] crt_byte_t;
  typedef logic [7:0] crt_addr_t;
  typedef logic [1:0] crt_prio_t;

  // internal i/o register offsets
  localparam crt_addr_t CRT_ADDR_CTRL_STATUS = 8'ha0;
  localparam crt_addr_t CRT_ADDR_PRESCALE = 8'ha1;
  localparam crt_addr_t CRT_ADDR_CLK_SRC = 8'ha4;

  // reload value register offsets, index 0 is subtimer one
  localparam crt_addr_t CRT_RELOAD_ADDR [CRT_NUM_TIMERS] = '{
    8'ha3, 8'ha5, 8'ha7, 8'ha9, 8'hab,
    8'had, 8'haf, 8'ha6, 8'ha8, 8'haa
  };

  // subtimer indices
  localparam int CRT_IDX_PRESCALE = 0;
  localparam int CRT_IDX_BAUD_LO = 1;
  localparam int CRT_IDX_BAUD_HI = 6;
  localparam int CRT_IDX_CAPTURE = 7;
  localparam int CRT_IDX_PWM = 8;
  localparam int CRT_IDX_QUAD = 9;

  // field positions
  localparam int CRT_CLK_EN_BIT = 0;
  localparam int CRT_DIV2_BIT = 0;
  localparam int CRT_GEN_LO = 1;
  localparam int CRT_GEN_HI = 7;
  localparam int CRT_SRC_LO = 2;
  localparam int CRT_SRC_HI = 7;
  localparam int CRT_PRIO_LO = 0;
  localparam int CRT_PRIO_HI = 1;

  // reset values
  localparam logic CRT_CLK_EN_RST = 1'b0;
  localparam logic CRT_DIV2_RST = 1'b1;
  localparam logic [CRT_NUM_GEN-1:0] CRT_GEN_EN_RST = 7'h00;
  localparam logic [CRT_NUM_GEN-1:0] CRT_STATUS_RST = 7'h00;
  localparam logic [CRT_NUM_BAUD-1:0] CRT_SRC_RST = 6'h00;
  localparam crt_prio_t CRT_PRIO_RST = 2'h0;
  localparam crt_prio_t CRT_PRIO_OFF = 2'h0;
  localparam crt_byte_t CRT_RELOAD_RST = 8'h00;
  localparam crt_byte_t CRT_COUNT_ZERO = 8'h00;
  localparam crt_byte_t CRT_COUNT_STEP = 8'h01;
  localparam crt_byte_t CRT_RDATA_RST = 8'h00;

endpackage : crt_pkg

// ---- src/crt_subtimer.sv ----
// one 8-bit reload down-counter with a one-cycle output pulse
`timescale 1ns/100ps
`default_nettype none
module crt_subtimer (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire crt_pkg::crt_byte_t reload,
  output var logic pulse_q
);
  import crt_pkg::*;

  crt_byte_t count_q;
  crt_byte_t count_d;
  logic at_zero;
  logic pulse_d;

  assign at_zero = (count_q == CRT_COUNT_ZERO);
  // at zero the next input pulse loads instead of counting
  assign count_d = at_zero ? reload : count_q - CRT_COUNT_STEP;
  // one pulse per reload+1 input pulses
  assign pulse_d = tick & at_zero;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= CRT_COUNT_ZERO;
    end else if (tick) begin
      count_q <= count_d;
    end
  end

  // registered pulse lasts one clock; consumers act on it a cycle later
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_d;
    end
  end

endmodule // crt_subtimer
`default_nettype wire

// ---- src/crt_timer_bank.sv ----
// bank of ten reload down-counters, six of them cascadable, with status and interrupt
`timescale 1ns/100ps
`default_nettype none
module crt_timer_bank (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire crt_pkg::crt_addr_t io_addr,
  input wire crt_pkg::crt_byte_t io_wdata,
  input wire logic io_wr_stb,
  input wire logic io_rd_stb,
  output var crt_pkg::crt_byte_t io_rdata_q,
  output var logic [crt_pkg::CRT_NUM_BAUD-1:0] baud_tick,
  output var logic prescale_tick,
  output var logic capture_tick,
  output var logic pwm_tick,
  output var logic quad_tick,
  output var logic irq_q,
  output var crt_pkg::crt_prio_t irq_prio_q
);
  import crt_pkg::*;

  // control state
  logic clk_en_q;
  logic div2_q;
  logic half_q;
  logic [CRT_NUM_GEN-1:0] gen_en_q;
  logic [CRT_NUM_GEN-1:0] status_q;
  logic [CRT_NUM_GEN-1:0] status_d;
  logic [CRT_NUM_BAUD-1:0] clk_src_q;
  crt_prio_t prio_q;
  crt_byte_t reload_q [CRT_NUM_TIMERS];

  // decode
  logic sel_csr;
  logic sel_prescale;
  logic sel_clk_src;
  logic wr_csr;
  logic wr_prescale;
  logic wr_clk_src;
  logic rd_csr;
  logic [CRT_NUM_TIMERS-1:0] wr_reload;
  crt_byte_t rd_value;
  crt_byte_t csr_read_value;

  // timing
  logic main_tick;
  logic [CRT_NUM_TIMERS-1:0] tick_w;
  logic [CRT_NUM_TIMERS-1:0] pulse_w;
  logic [CRT_NUM_GEN-1:0] gen_pulse;
  logic irq_d;

  assign sel_csr = (io_addr == CRT_ADDR_CTRL_STATUS);
  assign sel_prescale = (io_addr == CRT_ADDR_PRESCALE);
  assign sel_clk_src = (io_addr == CRT_ADDR_CLK_SRC);
  assign wr_csr = io_wr_stb & sel_csr;
  assign wr_prescale = io_wr_stb & sel_prescale;
  assign wr_clk_src = io_wr_stb & sel_clk_src;
  assign rd_csr = io_rd_stb & sel_csr;

  genvar gi;
  generate
    for (gi = 0; gi < CRT_NUM_TIMERS; gi++) begin : g_reload_dec
      assign wr_reload[gi] = io_wr_stb & (io_addr == CRT_RELOAD_ADDR[gi]);
    end
  endgenerate

  // reload values are plain registers, writable at any moment
  generate
    for (gi = 0; gi < CRT_NUM_TIMERS; gi++) begin : g_reload_reg
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          reload_q[gi] <= CRT_RELOAD_RST;
        end else if (wr_reload[gi]) begin
          reload_q[gi] <= io_wdata;
        end
      end
    end
  endgenerate

  // control/status write side: clock gate and interrupt enables
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_en_q <= CRT_CLK_EN_RST;
      gen_en_q <= CRT_GEN_EN_RST;
    end else if (wr_csr) begin
      clk_en_q <= io_wdata[CRT_CLK_EN_BIT];
      gen_en_q <= io_wdata[CRT_GEN_HI:CRT_GEN_LO];
    end
  end

  // only bit 0 of the prescale register is kept
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div2_q <= CRT_DIV2_RST;
    end else if (wr_prescale) begin
      div2_q <= io_wdata[CRT_DIV2_BIT];
    end
  end

  // clock-source selects and interrupt priority
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_src_q <= CRT_SRC_RST;
      prio_q <= CRT_PRIO_RST;
    end else if (wr_clk_src) begin
      clk_src_q <= io_wdata[CRT_SRC_HI:CRT_SRC_LO];
      prio_q <= io_wdata[CRT_PRIO_HI:CRT_PRIO_LO];
    end
  end

  // half-rate enable toggles only while the timer clock is on
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      half_q <= 1'b0;
    end else if (clk_en_q) begin
      half_q <= ~half_q;
    end
  end

  assign main_tick = clk_en_q & (~div2_q | half_q);

  // per-subtimer input selection
  generate
    for (gi = 0; gi < CRT_NUM_TIMERS; gi++) begin : g_tick_sel
      if (gi >= CRT_IDX_BAUD_LO && gi <= CRT_IDX_BAUD_HI) begin : g_baud
        // baud subtimers may cascade from the prescale subtimer
        assign tick_w[gi] = clk_src_q[gi-CRT_IDX_BAUD_LO]
                            ? pulse_w[CRT_IDX_PRESCALE]
                            : main_tick;
      end else begin : g_main
        // prescale and dedicated subtimers run from the main clock only
        assign tick_w[gi] = main_tick;
      end
    end
  endgenerate

  // the ten counters
  generate
    for (gi = 0; gi < CRT_NUM_TIMERS; gi++) begin : g_timer
      crt_subtimer u_subtimer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick_w[gi]),
        .reload(reload_q[gi]),
        .pulse_q(pulse_w[gi])
      );
    end
  endgenerate

  // fixed assignment of subtimers to consumers
  assign prescale_tick = pulse_w[CRT_IDX_PRESCALE];
  assign baud_tick = pulse_w[CRT_IDX_BAUD_HI:CRT_IDX_BAUD_LO];
  assign capture_tick = pulse_w[CRT_IDX_CAPTURE];
  assign pwm_tick = pulse_w[CRT_IDX_PWM];
  assign quad_tick = pulse_w[CRT_IDX_QUAD];

  // only the seven general subtimers feed the status register
  assign gen_pulse = pulse_w[CRT_NUM_GEN-1:0];

  // read clears; a pulse in the same cycle wins and survives the read
  assign status_d = (status_q & ~{CRT_NUM_GEN{rd_csr}})
                    | gen_pulse;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_q <= CRT_STATUS_RST;
    end else begin
      status_q <= status_d;
    end
  end

  // bit 0 is write-only and reads as zero
  assign csr_read_value = {status_q, 1'b0};
  // every other register is write-only and reads as zero
  assign rd_value = sel_csr ? csr_read_value : CRT_RDATA_RST;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_rdata_q <= CRT_RDATA_RST;
    end else if (io_rd_stb) begin
      io_rdata_q <= rd_value;
    end
  end

  // level request from the next status value, so a cleared bit never fires
  assign irq_d = (|(status_d & gen_en_q))
                 & (prio_q != CRT_PRIO_OFF);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      irq_prio_q <= CRT_PRIO_RST;
    end else begin
      irq_q <= irq_d;
      irq_prio_q <= prio_q;
    end
  end

endmodule // crt_timer_bank
`default_nettype wire

// ---- tb/crt_timer_bank_asserts.sv ----
// port assertions for the timer bank
`timescale 1ns/100ps
`default_nettype none
module crt_timer_bank_asserts (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire crt_pkg::crt_addr_t io_addr,
  input wire crt_pkg::crt_byte_t io_wdata,
  input wire logic io_wr_stb,
  input wire logic io_rd_stb,
  input wire crt_pkg::crt_byte_t io_rdata_q,
  input wire logic [crt_pkg::CRT_NUM_BAUD-1:0] baud_tick,
  input wire logic prescale_tick,
  input wire logic capture_tick,
  input wire logic pwm_tick,
  input wire logic quad_tick,
  input wire logic irq_q,
  input wire crt_pkg::crt_prio_t irq_prio_q
);
  import crt_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic rd_st;
  logic gen_p;
  assign rd_st = io_rd_stb && (io_addr == CRT_ADDR_CTRL_STATUS);
  assign gen_p = prescale_tick || (|baud_tick);
  a_prio_gates_irq: assert property (
    irq_prio_q == 2'h0 && $past(irq_prio_q) == 2'h0 |-> !irq_q)
    else $error("irq raised with priority off");
  a_read_drops_irq: assert property (rd_st && !gen_p |=> !irq_q)
    else $error("irq still high after status read");
  // a write one cycle earlier may legally drop enables or priority
  a_irq_holds: assert property (
    irq_q && !io_rd_stb && !io_wr_stb && !$past(io_wr_stb) |=> irq_q)
    else $error("irq dropped without a read");
  a_unmapped_read_zero: assert property (
    io_rd_stb && !rd_st |=> io_rdata_q == 8'h00)
    else $error("read of write-only place not zero");
  a_rdata_holds: assert property (!io_rd_stb |=> $stable(io_rdata_q))
    else $error("read data changed without a read");
  a_rdata_bit0_low: assert property (rd_st |=> !io_rdata_q[0])
    else $error("clock gate bit readable");
  a_pulse_reported: assert property (
    prescale_tick ##1 rd_st |=> io_rdata_q[1])
    else $error("pulse missing from status");
  a_no_lost_event: assert property (
    prescale_tick && rd_st ##1 rd_st |=> io_rdata_q[1])
    else $error("pulse during read lost");
  c_read_on_pulse: cover property (rd_st && gen_p);
  c_irq_rise: cover property ($rose(irq_q));
  c_irq_fall: cover property ($fell(irq_q));
endmodule // crt_timer_bank_asserts
bind crt_timer_bank crt_timer_bank_asserts u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_wr_stb(io_wr_stb), .io_rd_stb(io_rd_stb),
  .io_rdata_q(io_rdata_q), .baud_tick(baud_tick),
  .prescale_tick(prescale_tick), .capture_tick(capture_tick),
  .pwm_tick(pwm_tick), .quad_tick(quad_tick), .irq_q(irq_q),
  .irq_prio_q(irq_prio_q));
`default_nettype wire

// ---- tb/crt_serial_sink.sv ----
// serial port side model: counts baud clock pulses of all channels
`timescale 1ns/100ps
`default_nettype none
module crt_serial_sink (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [crt_pkg::CRT_NUM_BAUD-1:0] baud_tick,
  output var logic [15:0] rx_count_q
);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) rx_count_q <= 16'h0000;
    else rx_count_q <= rx_count_q + 16'($countones(baud_tick));
  end
endmodule // crt_serial_sink
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the timer bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  import crt_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  crt_addr_t io_addr = 8'h00;
  crt_byte_t io_wdata = 8'h00;
  logic io_wr_stb = 1'b0;
  logic io_rd_stb = 1'b0;
  crt_byte_t io_rdata_q, v;
  logic [CRT_NUM_BAUD-1:0] baud_tick;
  logic prescale_tick, capture_tick, pwm_tick, quad_tick, irq_q;
  crt_prio_t irq_prio_q;
  logic [9:0] all_tick;
  logic [15:0] rx_count;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;
  int rl [10] = '{0, 1, 2, 3, 4, 5, 6, 100, 254, 255};
  assign all_tick = {quad_tick, pwm_tick, capture_tick, baud_tick,
    prescale_tick};
  always #25 sys_clk = ~sys_clk;
  crt_timer_bank i_dut (.sys_clk(sys_clk), .resetn(resetn),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_wr_stb(io_wr_stb),
    .io_rd_stb(io_rd_stb), .io_rdata_q(io_rdata_q), .baud_tick(baud_tick),
    .prescale_tick(prescale_tick), .capture_tick(capture_tick),
    .pwm_tick(pwm_tick), .quad_tick(quad_tick), .irq_q(irq_q),
    .irq_prio_q(irq_prio_q));
  crt_serial_sink i_sink (.sys_clk(sys_clk), .resetn(resetn),
    .baud_tick(baud_tick), .rx_count_q(rx_count));
  task automatic chk(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input crt_addr_t a, input crt_byte_t d);
    @(posedge sys_clk);
    io_addr <= a;
    io_wdata <= d;
    io_wr_stb <= 1'b1;
    @(posedge sys_clk);
    io_wr_stb <= 1'b0;
  endtask
  task automatic rd(input crt_addr_t a, input int len, output crt_byte_t d);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd_stb <= 1'b1;
    repeat (len) @(posedge sys_clk);
    io_rd_stb <= 1'b0;
    #1 d = io_rdata_q;
  endtask
  // cycles from one output pulse of timer i to its next
  task automatic gap(input int i, output int g);
    #1 g = 0;
    while (all_tick[i] !== 1'b1 && g < 600) begin
      @(posedge sys_clk);
      #1 g++;
    end
    // first interval may straddle a rate or source change, so skip it
    repeat (2) begin
      g = 0;
      do begin
        @(posedge sys_clk);
        #1 g++;
      end while (all_tick[i] !== 1'b1 && g < 600);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_reset();
    rd(CRT_ADDR_CTRL_STATUS, 1, v);
    chk("status", v, 16'h0);
    repeat (20) @(posedge sys_clk);
    #1 chk("ticks", all_tick, 16'h0);
    chk("baud pulses", rx_count, 16'h0);
    $display("test reset done");
  endtask
  task automatic t_divide();
    wr(CRT_ADDR_PRESCALE, 8'h00);
    for (int i = 0; i < 10; i++) wr(CRT_RELOAD_ADDR[i], 8'(rl[i]));
    wr(CRT_ADDR_CTRL_STATUS, 8'h01);
    for (int i = 0; i < 10; i++) begin
      gap(i, n);
      chk("period", 16'(n), 16'(rl[i] + 1));
    end
    n = int'(rx_count);
    // baud periods 2..7 all divide 420 cycles: 669 pulses in all
    repeat (420) @(posedge sys_clk);
    #1 chk("baud pulses", rx_count - 16'(n), 16'd669);
    wr(CRT_ADDR_PRESCALE, 8'h01);
    gap(2, n);
    chk("half period", 16'(n), 16'h6);
    wr(CRT_ADDR_PRESCALE, 8'hfe);
    gap(2, n);
    chk("full period", 16'(n), 16'h3);
    $display("test divide done");
  endtask
  task automatic t_cascade();
    wr(CRT_RELOAD_ADDR[0], 8'h01);
    wr(CRT_ADDR_CLK_SRC, 8'h05);
    gap(1, n);
    chk("cascade period", 16'(n), 16'h4);
    gap(7, n);
    chk("capture period", 16'(n), 16'd101);
    chk("priority", irq_prio_q, 16'h1);
    $display("test cascade done");
  endtask
  task automatic t_status();
    wr(CRT_ADDR_CTRL_STATUS, 8'h03);
    repeat (8) @(posedge sys_clk);
    #1 chk("irq on", irq_q, 16'h1);
    rd(CRT_ADDR_CTRL_STATUS, 1, v);
    chk("status all", v, 16'hfe);
    // reload zero makes the prescale subtimer pulse every cycle, during the read too
    wr(CRT_RELOAD_ADDR[0], 8'h00);
    repeat (4) @(posedge sys_clk);
    rd(CRT_ADDR_CTRL_STATUS, 2, v);
    chk("status again", v[1], 16'h1);
    wr(CRT_ADDR_CTRL_STATUS, 8'h02);
    repeat (4) @(posedge sys_clk);
    rd(CRT_ADDR_CTRL_STATUS, 1, v);
    repeat (2) @(posedge sys_clk);
    #1 chk("irq off", irq_q, 16'h0);
    rd(CRT_ADDR_CTRL_STATUS, 1, v);
    chk("status clear", v, 16'h0);
    rd(CRT_RELOAD_ADDR[3], 1, v);
    chk("reload read", v, 16'h0);
    wr(CRT_ADDR_CLK_SRC, 8'h00);
    wr(CRT_ADDR_CTRL_STATUS, 8'h03);
    repeat (8) @(posedge sys_clk);
    #1 chk("irq masked", irq_q, 16'h0);
    $display("test status done");
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_divide();
    t_cascade();
    t_status();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
